// >>> src/odtc_pkg.sv
// constants and types shared by the termination timing control block
package odtc_pkg;
    // register bus
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control register fields
    localparam int CAS_LAT_W = 5;
    localparam int ADD_LAT_W = 5;
    localparam int LAT_W = 6;
    localparam int CTL_CAS_LAT_LSB = 0;
    localparam int CTL_ADD_LAT_LSB = 5;
    localparam int CTL_NOM_EN = 10;
    localparam int CTL_WR_EN = 11;
    localparam int CTL_PD_DLL_SEL = 12;
    localparam logic [CAS_LAT_W-1:0] CAS_LAT_RESET = 5'h05;
    localparam logic [ADD_LAT_W-1:0] ADD_LAT_RESET = 5'h00;
    // status register fields
    localparam int STS_RTT_ON = 0;
    localparam int STS_ASYNC = 1;
    localparam int STS_SYNC = 2;
    localparam int STS_HOLD_VIOL = 3;
    // latency and hold figures, in clock cycles
    localparam logic [LAT_W-1:0] LAT_OFFSET = 6'h02;
    localparam int DELAY_DEPTH = 32;
    localparam logic [2:0] HOLD_SHORT_CYC = 3'h4;
    localparam logic [2:0] HOLD_LONG_CYC = 3'h6;
    // analog delays of the asynchronous mode
    localparam int CLK_PERIOD_PS = 100000;
    localparam int ASYNC_DELAY_MIN_PS = 2000;
    localparam int ASYNC_DELAY_MAX_PS = 8500;
    localparam int ASYNC_MIN_RAW =
        (ASYNC_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_MAX_RAW = ASYNC_DELAY_MAX_PS / CLK_PERIOD_PS;
    localparam int ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
    localparam int ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
    // termination timing modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SYNC = 2'h1,
        MODE_ASYNC = 2'h3
    } odtc_mode_t;
endpackage

// >>> src/odtc_delay_line.sv
// pin history shift line with a selectable tap
`timescale 1ns/1ps
`default_nettype none
module odtc_delay_line
    import odtc_pkg::*;
#(
    parameter int DEPTH = DELAY_DEPTH
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic din,
    input wire logic [LAT_W-1:0] tap,
    output logic dout
);
    typedef struct packed {
        logic [DEPTH-1:0] line;
    } odtc_dl_state_t;

    odtc_dl_state_t s_q;
    odtc_dl_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.line = {s_q.line[DEPTH-2:0], din};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // tap n gives din as it was n-1 cycles ago
    always_comb
    begin
        if (tap <= LAT_W'(1))
            dout = din;
        else if (int'(tap) > DEPTH + 1)
            dout = s_q.line[DEPTH-1];
        else
            dout = s_q.line[int'(tap) - 2];
    end
endmodule
`default_nettype wire

// >>> src/odtc_term_ctrl.sv
// termination timing control with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - in synchronous mode termination turns on write latency less 2 cycles after a high sample.
// - in synchronous mode termination turns off write latency less 2 cycles after a low sample.
// - turn-off starts and reaches high impedance around the end of the off latency.
// - turn-on leaves high impedance and is fully on around the end of the on latency.
// - termination runs asynchronously in dll-off precharge power-down and during dll relock.
// - in asynchronous mode the additive latency is not applied to the pin.
// - asynchronous turn-on starts no sooner than 2 ns and completes by 8.5 ns after a high sample; this block turns on one 100 ns clock cycle later.
// - asynchronous turn-off starts no sooner than 2 ns and completes by 8.5 ns after a low sample; this block turns off one 100 ns clock cycle later.
// - synchronous timing is used when the dll is on and locked and a termination is enabled, except in precharge power-down with the dll select bit clear.
module odtc_term_ctrl
    import odtc_pkg::*;
#(
    parameter int DEPTH = DELAY_DEPTH
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic termination_control_pin,
    input wire logic write_strobe,
    input wire logic burst_chop_four,
    input wire logic precharge_powerdown,
    input wire logic dll_enabled,
    input wire logic dll_locked,
    output logic termination_enable,
    output logic termination_async_mode
);
    typedef struct packed {
        logic pin_meta;
        logic pin_s;
        logic pin_prev;
        logic [CAS_LAT_W-1:0] cas_write_latency;
        logic [ADD_LAT_W-1:0] additive_latency;
        logic nominal_termination;
        logic write_termination;
        logic powerdown_dll_select_bit;
        logic hold_viol;
        logic [2:0] hold_left;
        odtc_mode_t mode;
        logic rtt;
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } odtc_state_t;

    odtc_state_t s_q;
    odtc_state_t s_d;
    logic [LAT_W-1:0] term_on_latency;
    logic line_out;
    logic wr_go;
    logic [31:0] ctl_word;
    logic [31:0] ctl_new;
    logic [2:0] write_hold;

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    // write latency less 2, never below one cycle
    function automatic logic [LAT_W-1:0] latency_of(
        input logic [CAS_LAT_W-1:0] cas_lat,
        input logic [ADD_LAT_W-1:0] add_lat);
        logic [LAT_W-1:0] sum;
        sum = LAT_W'(cas_lat) + LAT_W'(add_lat);
        if (sum <= LAT_OFFSET + LAT_W'(1))
            return LAT_W'(1);
        return sum - LAT_OFFSET;
    endfunction

    assign term_on_latency = latency_of(s_q.cas_write_latency,
        s_q.additive_latency);

    odtc_delay_line #(
        .DEPTH(DEPTH)
    ) u_line (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(s_q.pin_s),
        .tap(term_on_latency),
        .dout(line_out)
    );

    assign ctl_word = {19'h00000, s_q.powerdown_dll_select_bit,
        s_q.write_termination, s_q.nominal_termination,
        s_q.additive_latency, s_q.cas_write_latency};
    assign ctl_new = merge_strb(ctl_word, s_q.w_data, s_q.w_strb);
    assign wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign write_hold = burst_chop_four ? HOLD_SHORT_CYC : HOLD_LONG_CYC;

    always_comb
    begin
        s_d = s_q;
        // pin sampler
        s_d.pin_meta = termination_control_pin;
        s_d.pin_s = s_q.pin_meta;
        s_d.pin_prev = s_q.pin_s;
        // mode select
        if (!(s_q.nominal_termination || s_q.write_termination))
            s_d.mode = MODE_OFF;
        else if (precharge_powerdown && !s_q.powerdown_dll_select_bit)
            s_d.mode = MODE_ASYNC;
        else if (dll_enabled && !dll_locked)
            s_d.mode = MODE_ASYNC;
        else if (dll_enabled)
            s_d.mode = MODE_SYNC;
        else
            s_d.mode = MODE_OFF;
        // termination state
        case (s_q.mode)
            MODE_SYNC: s_d.rtt = line_out;
            MODE_ASYNC: s_d.rtt = s_q.pin_s;
            MODE_OFF: s_d.rtt = 1'b0;
            default: s_d.rtt = 1'b0;
        endcase
        // minimum high time tracking
        if (s_q.hold_left != 3'h0)
            s_d.hold_left = s_q.hold_left - 3'h1;
        if (s_q.pin_s && !s_q.pin_prev)
            s_d.hold_left = HOLD_SHORT_CYC - 3'h1;
        if (s_q.pin_s && write_strobe
            && (write_hold - 3'h1) > s_d.hold_left)
            s_d.hold_left = write_hold - 3'h1;
        // write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_full = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (wr_go)
        begin
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (s_q.aw_addr)
                REG_CONTROL:
                begin
                    s_d.cas_write_latency =
                        ctl_new[CTL_CAS_LAT_LSB +: CAS_LAT_W];
                    s_d.additive_latency =
                        ctl_new[CTL_ADD_LAT_LSB +: ADD_LAT_W];
                    s_d.nominal_termination = ctl_new[CTL_NOM_EN];
                    s_d.write_termination = ctl_new[CTL_WR_EN];
                    s_d.powerdown_dll_select_bit =
                        ctl_new[CTL_PD_DLL_SEL];
                end
                REG_STATUS:
                begin
                    if (s_q.w_strb[0] && s_q.w_data[STS_HOLD_VIOL])
                        s_d.hold_viol = 1'b0;
                end
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        else if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        // early release seen on the pin; set wins over clear
        if (!s_q.pin_s && s_q.pin_prev && s_q.hold_left != 3'h0)
            s_d.hold_viol = 1'b1;
        // read channel
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            case (s_axi_araddr)
                REG_CONTROL: s_d.rdata = ctl_word;
                REG_STATUS:
                begin
                    s_d.rdata = 32'h00000000;
                    s_d.rdata[STS_RTT_ON] = s_q.rtt;
                    s_d.rdata[STS_ASYNC] = (s_q.mode == MODE_ASYNC);
                    s_d.rdata[STS_SYNC] = (s_q.mode == MODE_SYNC);
                    s_d.rdata[STS_HOLD_VIOL] = s_q.hold_viol;
                end
                default:
                begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.cas_write_latency <= CAS_LAT_RESET;
            s_q.additive_latency <= ADD_LAT_RESET;
            s_q.mode <= MODE_OFF;
        end
        else
            s_q <= s_d;
    end

    assign s_axi_awready = !s_q.aw_full;
    assign s_axi_wready = !s_q.w_full;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign termination_enable = s_q.rtt;
    assign termination_async_mode = (s_q.mode == MODE_ASYNC);

    // helper: cycles the sampled pin has kept its level
    logic [5:0] stable_cnt_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stable_cnt_q <= 6'h00;
        else if (s_q.pin_s != s_q.pin_prev)
            stable_cnt_q <= 6'h00;
        else if (stable_cnt_q != 6'h3F)
            stable_cnt_q <= stable_cnt_q + 6'h01;
    end

    localparam int ASYNC_DLY = ASYNC_MAX_CYC;

    a_sync_turn_on: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(s_q.mode) == MODE_SYNC && s_q.pin_s
        && s_q.pin_s == s_q.pin_prev
        && {1'b0, stable_cnt_q} + 7'h01 >= {1'b0, term_on_latency}
        && $stable(term_on_latency) |-> s_q.rtt)
        else $error("termination not on after on latency");
    a_sync_turn_off: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(s_q.mode) == MODE_SYNC && !s_q.pin_s
        && s_q.pin_s == s_q.pin_prev
        && {1'b0, stable_cnt_q} + 7'h01 >= {1'b0, term_on_latency}
        && $stable(term_on_latency) |-> !s_q.rtt)
        else $error("termination not off after off latency");
    a_off_not_early: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode == MODE_SYNC && s_q.rtt && !s_q.pin_s
        && s_q.pin_prev && term_on_latency > 6'h02
        && $stable(term_on_latency) |=> s_q.rtt)
        else $error("termination dropped before off latency");
    a_on_not_early: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode == MODE_SYNC && !s_q.rtt && s_q.pin_s
        && !s_q.pin_prev && term_on_latency > 6'h02
        && $stable(term_on_latency) |=> !s_q.rtt)
        else $error("termination rose before on latency");
    a_async_select: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_q.nominal_termination || s_q.write_termination)
        && ((precharge_powerdown && !s_q.powerdown_dll_select_bit)
        || (dll_enabled && !dll_locked))
        |=> termination_async_mode)
        else $error("asynchronous mode not selected");
    a_async_no_al: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode == MODE_ASYNC && $past(s_q.mode) == MODE_ASYNC
        |-> s_q.rtt == $past(s_q.pin_s))
        else $error("asynchronous path delayed by latency");
    a_async_on: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode == MODE_ASYNC && s_q.pin_s && !s_q.pin_prev
        ##ASYNC_DLY s_q.mode == MODE_ASYNC |-> s_q.rtt)
        else $error("asynchronous turn-on late");
    a_async_off: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode == MODE_ASYNC && !s_q.pin_s && s_q.pin_prev
        ##ASYNC_DLY s_q.mode == MODE_ASYNC |-> !s_q.rtt)
        else $error("asynchronous turn-off late");
    a_sync_select: assert property (@(posedge aclk) disable iff (!aresetn)
        dll_enabled && dll_locked
        && (s_q.nominal_termination || s_q.write_termination)
        && !(precharge_powerdown && !s_q.powerdown_dll_select_bit)
        && !wr_go |=> s_q.mode == MODE_SYNC)
        else $error("synchronous mode not selected");
    a_hold_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        !s_q.pin_s && s_q.pin_prev && s_q.hold_left != 3'h0
        |=> s_q.hold_viol [*2])
        else $error("early release not flagged");

    c_sync_on: cover property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode == MODE_SYNC && $rose(s_q.rtt));
    c_async_on: cover property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode == MODE_ASYNC && $rose(s_q.rtt));
    c_hold_viol: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_q.hold_viol));
endmodule
`default_nettype wire

// >>> src/odtc_fix_note.sv
// spare source unit, holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> verification/odtc_ctrl_model.sv
// controller side model driving the termination pin and write strobes
`timescale 1ns/1ps
`default_nettype none
module odtc_ctrl_model
(
    input wire logic aclk,
    output logic termination_control_pin,
    output logic write_strobe,
    output logic burst_chop_four
);
    // pin idles low between bursts, so reads see termination off
    initial
    begin
        termination_control_pin = 1'h0;
        write_strobe = 1'h0;
        burst_chop_four = 1'h0;
    end

    // one high period with an optional write; early skips the hold guard
    task automatic burst(input int hi, input int wr_at, input logic chop,
        input logic early);
        int need;
        need = 4;
        if (wr_at >= 0 && wr_at + (chop ? 4 : 6) > need)
            need = wr_at + (chop ? 4 : 6);
        if (!early && hi < need)
            hi = need;
        for (int i = 0; i <= hi + 2; i++)
        begin
            termination_control_pin <= (i < hi);
            // strobe lines up with the sampled pin, two edges late
            write_strobe <= (wr_at >= 0 && i == wr_at + 2);
            burst_chop_four <= chop;
            @(posedge aclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the termination timing control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import odtc_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic pin, wstb, chop, en, amode;
    logic pd = 1'h0, dll_en = 1'h1, dll_lk = 1'h1;
    logic pin_l = 1'h0, en_l = 1'h0;
    int bad_count = 0, compares = 0, cyc = 0, save = 0;
    int pin_up, pin_dn, en_up, en_dn;
    logic [31:0] cfg [4] = '{32'h1405, 32'h1866, 32'h14A5, 32'h1802};

    always #50 aclk = ~aclk;

    odtc_term_ctrl odtc_term_ctrl_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .termination_control_pin(pin), .write_strobe(wstb),
        .burst_chop_four(chop), .precharge_powerdown(pd),
        .dll_enabled(dll_en), .dll_locked(dll_lk),
        .termination_enable(en), .termination_async_mode(amode));

    odtc_ctrl_model odtc_ctrl_model_i (.aclk(aclk),
        .termination_control_pin(pin), .write_strobe(wstb),
        .burst_chop_four(chop));

    // edge stamps of pin and termination changes
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (pin === 1'h1 && pin_l !== 1'h1)
            pin_up = cyc;
        if (pin === 1'h0 && pin_l === 1'h1)
            pin_dn = cyc;
        if (en === 1'h1 && en_l !== 1'h1)
            en_up = cyc;
        if (en === 1'h0 && en_l === 1'h1)
            en_dn = cyc;
        pin_l = pin;
        en_l = en;
    end

    task automatic stop_test();
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic fail(input string m);
        bad_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chk_word(input logic [31:0] g, e, input string m);
        compares++;
        if (g !== e)
            fail(m);
    endtask

    task automatic chk_bit(input logic g, e, input string m);
        compares++;
        if (g !== e)
            fail(m);
    endtask

    task automatic chk_int(input int g, e, input string m);
        compares++;
        if (g != e)
            fail(m);
    endtask

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'h1)
                awvalid <= 1'h0;
            if (wvalid && wready === 1'h1)
                wvalid <= 1'h0;
            if (bvalid === 1'h1)
            begin
                r = bresp;
                bready <= 1'h0;
                return;
            end
        end
        fail("write timeout");
        stop_test();
    endtask

    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (arvalid && arready === 1'h1)
                arvalid <= 1'h0;
            if (rvalid === 1'h1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                return;
            end
        end
        fail("read timeout");
        stop_test();
    endtask

    function automatic int lat(input logic [31:0] c);
        int l;
        l = int'(c[4:0]) + int'(c[9:5]) - 2;
        return (l < 1 ? 1 : l) + 2;
    endfunction

    task automatic chk_mode(input logic [31:0] e);
        axi_rd(REG_STATUS, rd, rs);
        chk_word(rd & 32'h6, e, "mode bits");
    endtask

    // pin burst, then both edges of termination against the latency
    task automatic lat_run(input int hi, input int exp_lat);
        odtc_ctrl_model_i.burst(hi, -1, 1'h0, 1'h0);
        repeat (exp_lat + 2) @(posedge aclk);
        chk_int(en_up - pin_up, exp_lat, "on latency");
        chk_int(en_dn - pin_dn, exp_lat, "off latency");
    endtask

    // burst, read the sticky hold flag, then clear it
    task automatic hold_run(input int hi, wr, input logic c, early, exp);
        odtc_ctrl_model_i.burst(hi, wr, c, early);
        axi_rd(REG_STATUS, rd, rs);
        chk_bit(rd[STS_HOLD_VIOL], exp, "hold flag");
        axi_wr(REG_STATUS, 32'h8, rs);
    endtask

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        axi_rd(REG_CONTROL, rd, rs);
        chk_word(rd, 32'h5, "control reset value");
        axi_rd(REG_STATUS, rd, rs);
        chk_word(rd, 32'h0, "status reset value");
        axi_rd(4'h8, rd, rs);
        chk_word(rd, 32'h0, "unmapped read data");
        chk_word({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read resp");
        axi_wr(4'hC, 32'h1FFF, rs);
        chk_word({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write resp");
        axi_rd(REG_CONTROL, rd, rs);
        chk_word(rd, 32'h5, "control after unmapped write");
        for (int k = 0; k < 4; k++)
        begin
            axi_wr(REG_CONTROL, cfg[k], rs);
            chk_word({30'h0, rs}, {30'h0, RESP_OKAY}, "write resp");
            chk_mode(32'h4);
            lat_run(6, lat(cfg[k]));
        end
        hold_run(6, 1, 1'h0, 1'h0, 1'h0);
        hold_run(3, -1, 1'h0, 1'h1, 1'h1);
        hold_run(4, -1, 1'h0, 1'h0, 1'h0);
        hold_run(6, 1, 1'h0, 1'h1, 1'h1);
        hold_run(5, 1, 1'h1, 1'h0, 1'h0);
        hold_run(4, 1, 1'h1, 1'h1, 1'h1);
        axi_wr(REG_CONTROL, 32'h04A5, rs);
        axi_rd(REG_CONTROL, rd, rs);
        chk_word(rd, 32'h04A5, "control readback");
        pd <= 1'h1;
        repeat (3) @(posedge aclk);
        chk_bit(amode, 1'h1, "async mode flag");
        chk_mode(32'h2);
        lat_run(4, 3);
        pd <= 1'h0;
        dll_lk <= 1'h0;
        repeat (3) @(posedge aclk);
        chk_mode(32'h2);
        lat_run(4, 3);
        dll_lk <= 1'h1;
        repeat (3) @(posedge aclk);
        chk_bit(amode, 1'h0, "sync mode flag");
        axi_wr(REG_CONTROL, 32'h14A5, rs);
        pd <= 1'h1;
        repeat (3) @(posedge aclk);
        chk_mode(32'h4);
        lat_run(4, 10);
        pd <= 1'h0;
        dll_en <= 1'h0;
        repeat (3) @(posedge aclk);
        chk_mode(32'h0);
        save = en_up;
        odtc_ctrl_model_i.burst(4, -1, 1'h0, 1'h0);
        repeat (12) @(posedge aclk);
        chk_int(en_up, save, "termination in off mode");
        stop_test();
    end
endmodule
`default_nettype wire
